// file: bench/dancer_pid_speed_trim_tb.sv
// self-checking bench for the dancer speed trim block
`timescale 1ns/1ps
module dancer_pid_speed_trim_tb;
  import dancer_trim_pkg::*;
  logic CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic [4:0] ADDR_I = 5'h00;
  logic [15:0] WDATA_I = 16'h0000;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [4:0] TERM_I = 5'h00;
  logic RUN_I = 1'b1;
  logic FWD_I = 1'b0;
  logic MAIN_SRC_T2_I = 1'b0;
  logic [15:0] MAIN_SPEED_I = 16'h0800;
  logic [15:0] OUT_FREQ_I = 16'h1000;
  logic signed [15:0] PID_OUT_I = 16'sh0000;
  logic [11:0] pos = 12'h000;
  logic [11:0] ADC_I;
  logic [15:0] RDATA_O, SPEED_CMD_O, SET_POINT_O, MEASURED_O, e;
  logic [2:0] OUT_TERM_O;
  logic DANCER_ACTIVE_O, THERM_INPUT_O, rd_d;
  logic [4:0] adr;
  logic [20:0] q[$];
  int fails = 0;
  int checks_done = 0;
  int pid;
  logic [15:0] rb[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h03E8, 16'h03E8,
    16'h03E8};
  logic [15:0] rm[5] = '{16'h09C4, 16'h1388, 16'h1770, 16'h0320, 16'h0BB8};
  logic [15:0] rr[6] = '{16'h01F4, 16'h03E8, 16'h03E8, 16'h0000, 16'h01F4,
    16'h0000};
  logic [11:0] mc[3] = '{12'h800, 12'h400, 12'h999};
  logic [15:0] mv[3] = '{16'h01F4, 16'h01F4, 16'h01F3};
  logic [15:0] oc[8] = '{16'h000E, 16'h000F, 16'h0010, 16'h002F, 16'h0072,
    16'h0073, 16'h0074, 16'h0093};

  dancer_pid_speed_trim i_dancer_pid_speed_trim (.CLK_I, .RESET_I, .ADDR_I,
    .WDATA_I, .WR_I, .RD_I, .RDATA_O, .ADC_I, .TERM_I, .RUN_I, .FWD_I,
    .MAIN_SPEED_I, .MAIN_SRC_T2_I, .OUT_FREQ_I, .PID_OUT_I, .SPEED_CMD_O,
    .SET_POINT_O, .MEASURED_O, .OUT_TERM_O, .DANCER_ACTIVE_O,
    .THERM_INPUT_O);
  dancer_sensor_model i_dancer_sensor_model (.clk_i(CLK_I), .pos_i(pos),
    .adc_o(ADC_I));

  // 125 MHz clock
  always #4 CLK_I = ~CLK_I;

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ADDR_I <= a;
    WDATA_I <= d;
    RD_I <= 1'b0;
    WR_I <= 1'b1;
    @(posedge CLK_I);
  endtask : wr

  // note the expected word, then issue the read
  task automatic rd(input logic [4:0] a, input logic [15:0] d);
    q.push_back({a, d});
    ADDR_I <= a;
    WR_I <= 1'b0;
    RD_I <= 1'b1;
    @(posedge CLK_I);
  endtask : rd

  task automatic settle(input int n);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    repeat (n) @(posedge CLK_I);
  endtask : settle

  function automatic logic [15:0] rst_val(input logic [4:0] a);
    case (a)
      ADDR_UPPER, ADDR_LOWER, ADDR_SETPT, ADDR_THERM: rst_val = SENTINEL;
      ADDR_GAIN: rst_val = RST_GAIN;
      default: rst_val = (a >= ADDR_IN_FUNC0 && a < ADDR_NET_TERM) ?
        RST_IN_FUNC : 16'h0000;
    endcase
  endfunction : rst_val

  // held main 25 Hz, span 50 Hz, so ratio is half scale
  function automatic logic [15:0] spd(input int p, input int a);
    longint t;
    t = a[0] ? p : -p;
    if (a[1]) t = (t * 500 * 1049) >>> 20;
    t = 2500 + ((t * 5000 * 1049) >>> 20);
    spd = 16'(t);
  endfunction : spd

  // read data stands only in the cycle after the strobe
  always @(posedge CLK_I) begin
    rd_d <= RD_I && !RESET_I;
    if (rd_d === 1'b1) begin
      {adr, e} = q.pop_front();
      checks_done++;
      if (RDATA_O !== e) begin
        fails++;
        $display("[FAIL] reg %h expected %h seen %h", adr, e, RDATA_O);
      end
    end
  end

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // hang guard, far beyond the roughly 560 cycles needed
  initial begin
    repeat (20000) @(posedge CLK_I);
    fails++;
    results();
  end

  initial begin
    void'($urandom(82412));
    repeat (5) @(posedge CLK_I);
    RESET_I <= 1'b0;
    wr(5'h1F, 16'hFFFF);
    for (int a = 0; a < 32; a++) begin
      if (a < 17 || a > 19) rd(5'(a), rst_val(5'(a)));
    end
    // action codes around the dancer range, no enable pin
    for (int v = 38; v < 45; v++) begin
      wr(ADDR_ACTION, 16'(v));
      settle(8);
      rd(ADDR_STATUS, (v > 39 && v < 44) ? 16'h000B : 16'h0000);
    end
    // pin enable captures the output frequency
    wr(ADDR_IN_FUNC0 + 5'h02, FN_DANCER_EN);
    wr(ADDR_ACTION, 16'h0029);
    OUT_FREQ_I <= 16'h09C4;
    settle(8);
    rd(ADDR_STATUS, 16'h0004);
    TERM_I <= 5'h04;
    settle(8);
    OUT_FREQ_I <= 16'h1111;
    rd(ADDR_STATUS, 16'h000F);
    rd(ADDR_SPEED, 16'h09C4);
    pid = int'($urandom_range(400)) - 200;
    PID_OUT_I <= 16'(pid);
    for (int v = 40; v < 44; v++) begin
      wr(ADDR_ACTION, 16'(v));
      settle(16);
      rd(ADDR_SPEED, spd(pid, v));
    end
    // network bit takes over from the pin, then drops out
    TERM_I <= 5'h00;
    wr(ADDR_NET_TERM, 16'h0004);
    settle(8);
    rd(ADDR_STATUS, 16'h000F);
    wr(ADDR_NET_TERM, 16'h0000);
    settle(8);
    rd(ADDR_STATUS, 16'h0004);
    rd(ADDR_SPEED, MAIN_SPEED_I);
    PID_OUT_I <= 16'sh0000;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_BIAS, rb[i]);
      MAIN_SPEED_I <= (i == 5) ? 16'($urandom_range(999)) : rm[i];
      settle(24);
      rd(ADDR_RATIO, rr[i]);
    end
    // scaling per input type against strict limits
    wr(ADDR_BIAS, RST_BIAS);
    FWD_I <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pos <= mc[i];
      wr(ADDR_INTYPE, 16'(2 - i));
      wr(ADDR_UPPER, mv[i] - 16'h0001);
      wr(ADDR_LOWER, mv[i] + 16'h0001);
      settle(8);
      rd(ADDR_STATUS, 16'h0074);
      wr(ADDR_UPPER, mv[i]);
      wr(ADDR_LOWER, mv[i]);
      settle(8);
      rd(ADDR_STATUS, 16'h0014);
    end
    foreach (oc[i]) begin
      wr(ADDR_OUT_FUNC0, oc[i]);
      settle(10);
    end
    wr(ADDR_THERM, 16'h0064);
    MAIN_SRC_T2_I <= 1'b1;
    RUN_I <= 1'b0;
    settle(8);
    rd(ADDR_SPEED, 16'h0000);
    // output suspension stays at 9999 upstream; never requested here
    wr(ADDR_SETPT, 16'h0320);
    settle(4);
    rd(ADDR_SETPT, 16'h0320);
    wr(ADDR_SETPT, SENTINEL);
    settle(4);
    rd(ADDR_SETPT, SENTINEL);
    settle(3);
    results();
  end
endmodule : dancer_pid_speed_trim_tb

// file: bench/dancer_sensor_model.sv
// roller position detector feeding the measured input
`timescale 1ns/1ps
module dancer_sensor_model (
  input wire logic clk_i, // control clock
  input wire logic [11:0] pos_i, // roller position code
  output logic [11:0] adc_o // converter code
);
  // sampled converter, one clock behind the roller
  always_ff @(posedge clk_i) begin
    adc_o <= pos_i;
  end
endmodule : dancer_sensor_model

// file: bench/dancer_trim_props.sv
// port assertions for the dancer speed trim block
`timescale 1ns/1ps
module dancer_trim_props
  import dancer_trim_pkg::*;
(
  input wire logic CLK_I, // clock
  input wire logic RESET_I, // reset
  input wire logic [4:0] ADDR_I, // address
  input wire logic [15:0] WDATA_I, // write data
  input wire logic WR_I, // write
  input wire logic RD_I, // read
  input wire logic [15:0] RDATA_O, // read data
  input wire logic FWD_I, // forward
  input wire logic RUN_I, // running
  input wire logic [15:0] MAIN_SPEED_I, // main speed
  input wire logic MAIN_SRC_T2_I, // from input 2
  input wire logic signed [15:0] PID_OUT_I, // pid
  input wire logic [15:0] SPEED_CMD_O, // speed
  input wire logic [15:0] SET_POINT_O, // set point
  input wire logic [15:0] MEASURED_O, // measured
  input wire logic [2:0] OUT_TERM_O, // out pins
  input wire logic DANCER_ACTIVE_O, // active
  input wire logic THERM_INPUT_O // thermistor
);
  logic [15:0] act, fn0, up, lo, thr, base, sp;
  logic [2:0] calm;
  logic flag0, in_range;

  // shadow of the registers that steer flags and the set point, snooped off the bus
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      act <= RST_ACTION;
      fn0 <= RST_OUT_FUNC;
      up <= SENTINEL;
      lo <= SENTINEL;
      thr <= SENTINEL;
      sp <= SENTINEL;
    end else if (WR_I) begin
      if (ADDR_I == ADDR_SETPT) sp <= WDATA_I;
      if (ADDR_I == ADDR_ACTION) act <= WDATA_I;
      if (ADDR_I == ADDR_OUT_FUNC0) fn0 <= WDATA_I;
      if (ADDR_I == ADDR_UPPER) up <= WDATA_I;
      if (ADDR_I == ADDR_LOWER) lo <= WDATA_I;
      if (ADDR_I == ADDR_THERM) thr <= WDATA_I;
    end
  end

  // quiet time, so pipeline latency never trips the flag check
  always_ff @(posedge CLK_I) begin
    if (RESET_I || WR_I || $changed(MEASURED_O) || $changed(FWD_I)
        || $changed(DANCER_ACTIVE_O)) begin
      calm <= 3'h0;
    end else if (calm != 3'h7) begin
      calm <= calm + 3'h1;
    end
  end

  // expected level of output terminal 0
  always_comb begin
    base = (fn0 >= NEG_OFFSET) ? fn0 - NEG_OFFSET : fn0;
    in_range = act >= ACT_REV_FIXED && act <= ACT_FWD_RATIO;
    case (base)
      FN_LOWER: flag0 = in_range && lo != SENTINEL && MEASURED_O < lo;
      FN_UPPER: flag0 = in_range && up != SENTINEL && MEASURED_O > up;
      FN_DIR: flag0 = FWD_I;
      FN_PID: flag0 = DANCER_ACTIVE_O;
      default: flag0 = 1'b0;
    endcase
    flag0 = flag0 ^ (fn0 >= NEG_OFFSET);
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  a_reset_outs: assert property (disable iff (1'b0)
    RESET_I |=> SET_POINT_O == PCT_HALF && !DANCER_ACTIVE_O)
    else $error("outputs wrong after reset");
  a_read_idle: assert property (
    !RD_I |=> RDATA_O == 16'h0000)
    else $error("read data outside read slot");
  a_measured_span: assert property (
    MEASURED_O <= PCT_FULL)
    else $error("measured above full scale");
  a_plain_speed: assert property (
    (!DANCER_ACTIVE_O && !MAIN_SRC_T2_I && $stable(MAIN_SPEED_I))[*4]
    |-> SPEED_CMD_O == MAIN_SPEED_I)
    else $error("speed differs from main speed");
  a_hold_speed: assert property (
    (DANCER_ACTIVE_O && RUN_I && PID_OUT_I == 16'sh0000)[*4]
    |-> $stable(SPEED_CMD_O))
    else $error("held speed moved");
  a_term_zero: assert property (
    calm == 3'h7 |-> OUT_TERM_O[0] == flag0)
    else $error("output terminal 0 wrong");
  a_action_off: assert property (
    (act == 16'h0000)[*4] |-> !DANCER_ACTIVE_O)
    else $error("dancer active with action zero");
  a_therm_flag: assert property (
    $stable(thr)[*3] |-> THERM_INPUT_O == (thr != SENTINEL))
    else $error("thermistor flag wrong");
  a_set_point: assert property (
    $stable(sp)[*2] |-> SET_POINT_O == ((sp == SENTINEL) ? PCT_HALF : sp))
    else $error("set point output wrong");
endmodule : dancer_trim_props

bind dancer_pid_speed_trim dancer_trim_props i_dancer_trim_props (.CLK_I,
  .RESET_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .FWD_I, .RUN_I,
  .MAIN_SPEED_I, .MAIN_SRC_T2_I, .PID_OUT_I, .SPEED_CMD_O, .SET_POINT_O,
  .MEASURED_O, .OUT_TERM_O, .DANCER_ACTIVE_O, .THERM_INPUT_O);

// file: hdl/dancer_pid_speed_trim.sv
// dancer roller pid speed trim with limit and status terminals
`timescale 1ns/1ps

// Operation
// - action zero or enable off: no correction
// - unassigned enable: action range alone enables
// - input terminal code 14 is dancer enable
// - upper flag above maximum unless 9999
// - lower flag below minimum unless 9999
// - direction flag high only when forward
// - pid flag while dancer control runs
// - function code 100 up inverts output
// - action 40..43 decode reverse/forward fixed/ratio
// - ratio modes scale pid by main ratio
// - ratio maps main speed bias..gain linearly
// - gain end 100 %, bias end 0 %
// - main below nonzero bias gives ratio 0
// - enable on while running captures output frequency
// - enable off while running keeps set frequency
// - percent maps bias..gain frequency span
// - set point 9999 means 50 percent
// - thermistor level set blocks terminal 2 speed
// - network bits act as enable terminal
// - pid correction added to main speed
module dancer_pid_speed_trim (
  input wire logic CLK_I, // control clock, 125 MHz
  input wire logic RESET_I, // synchronous reset, active high
  input wire logic [dancer_trim_pkg::ADDR_W-1:0] ADDR_I, // register address
  input wire logic [dancer_trim_pkg::DATA_W-1:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [dancer_trim_pkg::DATA_W-1:0] RDATA_O, // read data
  input wire logic [dancer_trim_pkg::ADC_W-1:0] ADC_I, // measured input
  input wire logic [dancer_trim_pkg::N_IN-1:0] TERM_I, // input pins
  input wire logic RUN_I, // drive is running
  input wire logic FWD_I, // forward rotation shown
  input wire logic [15:0] MAIN_SPEED_I, // main speed, 0.01 Hz
  input wire logic MAIN_SRC_T2_I, // main speed from input 2
  input wire logic [15:0] OUT_FREQ_I, // output frequency
  input wire logic signed [15:0] PID_OUT_I, // pid result, 0.1 %
  output logic [15:0] SPEED_CMD_O, // speed command
  output logic [15:0] SET_POINT_O, // set point to pid core
  output logic [15:0] MEASURED_O, // measured value to core
  output logic [dancer_trim_pkg::N_OUT-1:0] OUT_TERM_O, // out pins
  output logic DANCER_ACTIVE_O, // dancer control running
  output logic THERM_INPUT_O // input 2 is thermistor
);
  import dancer_trim_pkg::*;

  typedef enum logic {S_LOAD, S_DIV} div_state_t;

  logic [15:0] action, upper_lim, lower_lim, set_pt, in_type;
  logic [15:0] therm_lvl, bias_freq, gain_freq;
  logic [15:0] in_func [N_IN];
  logic [15:0] out_func [N_OUT];
  logic [N_IN-1:0] net_term;
  logic [ADC_W-1:0] adc_s1, adc_s2;
  logic [N_IN-1:0] term_s1, term_s2;
  logic [N_IN-1:0] term_eff;
  logic en_assigned, en_hit, dancer_mode, next_active;
  logic dancer_active, prev_active, hold_on;
  logic [15:0] hold_speed, main_src, main_used, span;
  logic [11:0] raw_off;
  logic [27:0] prod;
  logic [15:0] next_meas;
  flags_t flags;
  div_state_t div_state;
  logic [25:0] rem, dsr;
  logic [9:0] quo;
  logic [3:0] step;
  logic [15:0] ratio;
  logic signed [47:0] pid_s, pct_s, trim_s, sum_s;
  logic signed [47:0] ratio_s, span_s, recip_s, main_s;
  logic [15:0] next_speed;

  // output function decode with optional negative logic
  function automatic logic term_level(input logic [15:0] code,
                                      input flags_t f);
    logic [15:0] base;
    logic neg;
    logic v;
    neg = code >= NEG_OFFSET;
    base = neg ? code - NEG_OFFSET : code;
    case (base)
      FN_LOWER: v = f.lower;
      FN_UPPER: v = f.upper;
      FN_DIR: v = f.fwd;
      FN_PID: v = f.pid;
      default: v = 1'b0;
    endcase
    return neg ? ~v : v;
  endfunction : term_level

  // register writes
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      action <= RST_ACTION;
      upper_lim <= SENTINEL;
      lower_lim <= SENTINEL;
      set_pt <= SENTINEL;
      in_type <= RST_INTYPE;
      therm_lvl <= SENTINEL;
      bias_freq <= RST_BIAS;
      gain_freq <= RST_GAIN;
      net_term <= '0;
      for (int i = 0; i < N_IN; i++) in_func[i] <= RST_IN_FUNC;
      for (int i = 0; i < N_OUT; i++) out_func[i] <= RST_OUT_FUNC;
    end else if (WR_I) begin
      case (ADDR_I)
        ADDR_ACTION: action <= WDATA_I;
        ADDR_UPPER: upper_lim <= WDATA_I;
        ADDR_LOWER: lower_lim <= WDATA_I;
        ADDR_SETPT: set_pt <= WDATA_I;
        ADDR_INTYPE: in_type <= WDATA_I;
        ADDR_THERM: therm_lvl <= WDATA_I;
        ADDR_BIAS: bias_freq <= WDATA_I;
        ADDR_GAIN: gain_freq <= WDATA_I;
        ADDR_NET_TERM: net_term <= WDATA_I[N_IN-1:0];
        default: ;
      endcase
      for (int i = 0; i < N_IN; i++) begin
        if (ADDR_I == ADDR_IN_FUNC0 + ADDR_W'(i)) in_func[i] <= WDATA_I;
      end
      for (int i = 0; i < N_OUT; i++) begin
        if (ADDR_I == ADDR_OUT_FUNC0 + ADDR_W'(i)) out_func[i] <= WDATA_I;
      end
    end
  end

  // register reads, data valid the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      RDATA_O <= '0;
    end else begin
      RDATA_O <= '0;
      if (RD_I) begin
        case (ADDR_I)
          ADDR_ACTION: RDATA_O <= action;
          ADDR_UPPER: RDATA_O <= upper_lim;
          ADDR_LOWER: RDATA_O <= lower_lim;
          ADDR_SETPT: RDATA_O <= set_pt;
          ADDR_INTYPE: RDATA_O <= in_type;
          ADDR_THERM: RDATA_O <= therm_lvl;
          ADDR_BIAS: RDATA_O <= bias_freq;
          ADDR_GAIN: RDATA_O <= gain_freq;
          ADDR_NET_TERM: RDATA_O <= {11'h000, net_term};
          ADDR_STATUS: RDATA_O <= {9'h000, flags, en_assigned, hold_on,
                                   dancer_active};
          ADDR_RATIO: RDATA_O <= ratio;
          ADDR_SPEED: RDATA_O <= SPEED_CMD_O;
          default: RDATA_O <= '0;
        endcase
        for (int i = 0; i < N_IN; i++) begin
          if (ADDR_I == ADDR_IN_FUNC0 + ADDR_W'(i)) RDATA_O <= in_func[i];
        end
        for (int i = 0; i < N_OUT; i++) begin
          if (ADDR_I == ADDR_OUT_FUNC0 + ADDR_W'(i)) RDATA_O <= out_func[i];
        end
      end
    end
  end

  // pins are asynchronous, two stages before use
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      adc_s1 <= '0;
      adc_s2 <= '0;
      term_s1 <= '0;
      term_s2 <= '0;
    end else begin
      adc_s1 <= ADC_I;
      adc_s2 <= adc_s1;
      term_s1 <= TERM_I;
      term_s2 <= term_s1;
    end
  end

  // enable request: pin or network bit on a code 14 terminal
  always_comb begin
    term_eff = term_s2 | net_term;
    en_assigned = 1'b0;
    en_hit = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (in_func[i] == FN_DANCER_EN) begin
        en_assigned = 1'b1;
        en_hit = en_hit | term_eff[i];
      end
    end
    dancer_mode = action >= ACT_REV_FIXED && action <= ACT_FWD_RATIO;
    next_active = dancer_mode && (!en_assigned || en_hit);
  end

  // main speed source; input 2 refused once it is the thermistor
  always_comb begin
    if (therm_lvl != SENTINEL && MAIN_SRC_T2_I) main_src = 16'h0000;
    else main_src = MAIN_SPEED_I;
    main_used = hold_on ? hold_speed : main_src;
    span = gain_freq > bias_freq ? gain_freq - bias_freq : 16'h0000;
  end

  // enable edges while running: capture or release the speed
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dancer_active <= 1'b0;
      prev_active <= 1'b0;
      hold_on <= 1'b0;
      hold_speed <= '0;
    end else begin
      dancer_active <= next_active;
      prev_active <= dancer_active;
      if (!RUN_I) begin
        hold_on <= 1'b0;
      end else if (dancer_active && !prev_active) begin
        hold_on <= 1'b1;
        hold_speed <= OUT_FREQ_I;
      end else if (!dancer_active && prev_active) begin
        hold_on <= 1'b0;
      end
    end
  end

  // measured value scaling to 0..1000 in 0.1 % steps
  always_comb begin
    raw_off = adc_s2 > ADC_4MA ? adc_s2 - ADC_4MA : 12'h000;
    if (in_type == IN_TYPE_CUR) prod = 28'(raw_off) * 28'(SCALE_CUR);
    else if (in_type == IN_TYPE_V5) prod = 28'(adc_s2) * 28'(SCALE_V5);
    else prod = 28'(adc_s2) * 28'(SCALE_V10);
    next_meas = prod[27:ADC_SHIFT];
    if (next_meas > PCT_FULL) next_meas = PCT_FULL;
  end

  // measured value, set point and flags, refreshed every cycle
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      MEASURED_O <= '0;
      SET_POINT_O <= PCT_HALF;
      flags <= '0;
      THERM_INPUT_O <= 1'b0;
    end else begin
      MEASURED_O <= next_meas;
      SET_POINT_O <= set_pt == SENTINEL ? PCT_HALF : set_pt;
      flags.upper <= dancer_mode && upper_lim != SENTINEL
                     && MEASURED_O > upper_lim;
      flags.lower <= dancer_mode && lower_lim != SENTINEL
                     && MEASURED_O < lower_lim;
      flags.fwd <= FWD_I;
      flags.pid <= dancer_active;
      THERM_INPUT_O <= therm_lvl != SENTINEL;
    end
  end

  // ratio of main speed; serial divider avoids a wide comb divide
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      div_state <= S_LOAD;
      rem <= '0;
      dsr <= '0;
      quo <= '0;
      step <= '0;
      ratio <= '0;
    end else begin
      unique case (div_state)
        S_LOAD: begin
          if (main_used <= bias_freq || span == 16'h0000) begin
            ratio <= '0;
          end else if (main_used >= gain_freq) begin
            ratio <= PCT_FULL;
          end else begin
            rem <= 26'(main_used - bias_freq) * 26'(PCT_FULL);
            dsr <= 26'(span) << 9;
            quo <= '0;
            step <= '0;
            div_state <= S_DIV;
          end
        end
        S_DIV: begin
          if (rem >= dsr) rem <= rem - dsr;
          quo <= {quo[8:0], rem >= dsr};
          dsr <= dsr >> 1;
          step <= step + 4'h1;
          if (step == DIV_LAST) begin
            ratio <= {6'h00, quo[8:0], rem >= dsr};
            div_state <= S_LOAD;
          end
        end
      endcase
    end
  end

  // correction: action sign, optional ratio, percent to frequency
  always_comb begin
    ratio_s = $signed({32'h0000_0000, ratio});
    span_s = $signed({32'h0000_0000, span});
    recip_s = $signed({32'h0000_0000, RECIP_1000});
    main_s = $signed({32'h0000_0000, main_used});
    pid_s = 48'(PID_OUT_I);
    if (!action[0]) pid_s = -pid_s;
    if (action[1]) pct_s = (pid_s * ratio_s * recip_s) >>> RECIP_SHIFT;
    else pct_s = pid_s;
    trim_s = (pct_s * span_s * recip_s) >>> RECIP_SHIFT;
    sum_s = main_s + trim_s;
    if (!dancer_active) next_speed = main_used;
    else if (sum_s < 48'sh0) next_speed = 16'h0000;
    else if (sum_s > 48'sh0000_0000_FFFF) next_speed = 16'hFFFF;
    else next_speed = sum_s[15:0];
  end

  // registered outputs
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      SPEED_CMD_O <= '0;
      DANCER_ACTIVE_O <= 1'b0;
      OUT_TERM_O <= '0;
    end else begin
      SPEED_CMD_O <= next_speed;
      DANCER_ACTIVE_O <= dancer_active;
      for (int i = 0; i < N_OUT; i++) begin
        OUT_TERM_O[i] <= term_level(out_func[i], flags);
      end
    end
  end
endmodule : dancer_pid_speed_trim

// file: hdl/dancer_trim_pkg.sv
// shared constants and types for the dancer speed trim block
package dancer_trim_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int ADC_W = 12;
  localparam int N_IN = 5;
  localparam int N_OUT = 3;

  // register addresses
  localparam logic [4:0] ADDR_ACTION = 5'h00;
  localparam logic [4:0] ADDR_UPPER = 5'h01;
  localparam logic [4:0] ADDR_LOWER = 5'h02;
  localparam logic [4:0] ADDR_SETPT = 5'h03;
  localparam logic [4:0] ADDR_INTYPE = 5'h04;
  localparam logic [4:0] ADDR_THERM = 5'h05;
  localparam logic [4:0] ADDR_BIAS = 5'h06;
  localparam logic [4:0] ADDR_GAIN = 5'h07;
  localparam logic [4:0] ADDR_IN_FUNC0 = 5'h08;
  localparam logic [4:0] ADDR_OUT_FUNC0 = 5'h0D;
  localparam logic [4:0] ADDR_NET_TERM = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h11;
  localparam logic [4:0] ADDR_RATIO = 5'h12;
  localparam logic [4:0] ADDR_SPEED = 5'h13;

  // reset values
  localparam logic [15:0] SENTINEL = 16'h270F;
  localparam logic [15:0] RST_ACTION = 16'h0000;
  localparam logic [15:0] RST_INTYPE = 16'h0000;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h1388;
  localparam logic [15:0] RST_IN_FUNC = 16'h00FF;
  localparam logic [15:0] RST_OUT_FUNC = 16'h00FF;

  // action and function codes
  localparam logic [15:0] ACT_REV_FIXED = 16'h0028;
  localparam logic [15:0] ACT_FWD_RATIO = 16'h002B;
  localparam logic [15:0] FN_DANCER_EN = 16'h000E;
  localparam logic [15:0] FN_LOWER = 16'h000E;
  localparam logic [15:0] FN_UPPER = 16'h000F;
  localparam logic [15:0] FN_DIR = 16'h0010;
  localparam logic [15:0] FN_PID = 16'h002F;
  localparam logic [15:0] NEG_OFFSET = 16'h0064;

  // percent scale, 0.1 % steps
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  localparam logic [15:0] PCT_HALF = 16'h01F4;

  // measured input scaling, adc full scale is 10 V or 20 mA
  localparam logic [15:0] IN_TYPE_CUR = 16'h0000;
  localparam logic [15:0] IN_TYPE_V5 = 16'h0001;
  localparam logic [11:0] ADC_4MA = 12'h333;
  localparam logic [15:0] SCALE_CUR = 16'h04E2;
  localparam logic [15:0] SCALE_V5 = 16'h07D0;
  localparam logic [15:0] SCALE_V10 = 16'h03E8;
  localparam int ADC_SHIFT = 12;

  // divide by 1000 as multiply and shift
  localparam logic [15:0] RECIP_1000 = 16'h0419;
  localparam int RECIP_SHIFT = 20;

  // ratio divider length
  localparam logic [3:0] DIV_LAST = 4'h9;

  typedef struct packed {
    logic upper;
    logic lower;
    logic fwd;
    logic pid;
  } flags_t;
endpackage : dancer_trim_pkg
